// *** hdl/owt_pkg.sv ***
/*
  constants and types for the one-wire byte transmitter.
  assumes a single clock at 200 MHz and a simple register port.
*/
`default_nettype none
package owt_pkg;
  localparam int unsigned CLK_MHZ     = 200;
  localparam logic [3:0]  OFS_CONFIG  = 4'h0;
  localparam logic [3:0]  OFS_TIMING  = 4'h4;
  localparam logic [3:0]  OFS_EVENT   = 4'h8;
  localparam logic [3:0]  OFS_TXBYTE  = 4'hc;
  localparam int unsigned BIT_EN      = 0;
  localparam int unsigned BIT_MSBF    = 1;
  localparam int unsigned BIT_LAST    = 4;
  localparam int unsigned BIT_RATIO   = 0;
  localparam int unsigned BIT_DONE    = 4;
  localparam int unsigned BIT_IEN     = 0;
  localparam int unsigned TB_LO       = 4;
  localparam int unsigned UNIT_DEF_US = 32;
  // each bit symbol spans 4 units (3:1) or 3 units (2:1); start is a long low
  localparam logic [2:0]  SYM_UNITS_31 = 3'h4;
  localparam logic [2:0]  SYM_UNITS_21 = 3'h3;
  localparam logic [5:0]  START_UNITS  = 6'h20;

  typedef enum logic [1:0] {
    OWT_IDLE  = 2'b00,
    OWT_START = 2'b01,
    OWT_BITS  = 2'b10,
    OWT_HOLD  = 2'b11
  } owt_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } owt_bus_t;
endpackage
`default_nettype wire

// *** hdl/owt_top.sv ***
/*
  one-wire byte transmitter: register port, symbol timer, serialiser, interrupt.
  assumes synchronous inputs and a master that never needs wait states.
*/
`default_nettype none
// What this block does
// R1 - last-byte bit ends transfer after byte
// R2 - done event when byte fully shifted
// R3 - without last-byte, stay open, no idle
// R4 - bit order: 1 msb first, 0 lsb
// R5 - transmit only while enabled, reset off
// R6 - time unit from 4-bit selector table
// R7 - ratio bit picks 3:1 or 2:1
// R8 - done flag sticky, write 1 clears
// R9 - irq while flag and enable set
// R10 - byte write starts transmission when enabled
// R11 - four registers at 0x0, 0x4, 0x8, 0xc
// R12 - single output line, send only
// R13 - no dma; one event per byte
// R14 - own symbol waveforms and idle level
module owt_top #(
  parameter int unsigned CLK_MHZ = owt_pkg::CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  output logic             line_o
);
  import owt_pkg::*;

  // time unit in microseconds from the 4-bit selector
  function automatic logic [8:0] owt_unit_us(input logic [3:0] sel);
    case (sel)
      4'h1:    owt_unit_us = 9'h020;
      4'h2:    owt_unit_us = 9'h040;
      4'h3:    owt_unit_us = 9'h060;
      4'h4:    owt_unit_us = 9'h080;
      4'h5:    owt_unit_us = 9'h0a0;
      4'h6:    owt_unit_us = 9'h0c0;
      4'h7:    owt_unit_us = 9'h0dc;
      4'h8:    owt_unit_us = 9'h100;
      4'h9:    owt_unit_us = 9'h120;
      4'ha:    owt_unit_us = 9'h140;
      default: owt_unit_us = 9'(UNIT_DEF_US);
    endcase
  endfunction

  owt_bus_t bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic        en_q, msbf_q, ratio_q, ien_q, done_q, last_q, line_q;
  logic [3:0]  tsel_q;
  logic [7:0]  data_q, shift_q;
  logic [31:0] rdata_q;
  logic [16:0] tick_q;
  logic [5:0]  unit_q;
  logic [2:0]  bit_q;
  owt_state_t  state_q, state_d;

  // [R11] address decode
  wire wr_cfg  = bus.wr && bus.addr == OFS_CONFIG;
  wire wr_tim  = bus.wr && bus.addr == OFS_TIMING;
  wire wr_evt  = bus.wr && bus.addr == OFS_EVENT;
  wire wr_byte = bus.wr && bus.addr == OFS_TXBYTE;
  wire last_wr = wr_cfg && bus.wdata[BIT_LAST]; // [R1]

  // [R6] cycles per unit; widened so the product cannot wrap
  wire [16:0] unit_cyc = 17'(owt_unit_us(tsel_q) * 17'(CLK_MHZ));
  // compare with >= so a selector change mid-unit cannot let the counter run away
  wire        tick     = tick_q >= unit_cyc - 17'h1;
  wire [2:0]  sym_len  = ratio_q ? SYM_UNITS_31 : SYM_UNITS_21; // [R7]
  // [R14] bit 1: high for all but last unit; bit 0: high one unit only
  wire [7:0]  shifted  = msbf_q ? {shift_q[6:0], 1'b0} : {1'b0, shift_q[7:1]};
  wire        cur_bit  = msbf_q ? shift_q[7] : shift_q[0]; // [R4]
  // ratio may change mid-symbol, so the end test must not need an exact hit
  wire        sym_end  = tick && unit_q >= 6'(sym_len) - 6'h1;
  wire        start_ok = en_q && wr_byte; // [R10] [R5]
  wire        start_end = tick && unit_q >= START_UNITS - 6'h1;

  always_comb begin
    state_d = state_q;
    case (state_q)
      OWT_IDLE: begin
        if (start_ok) state_d = OWT_START;
      end
      OWT_START: begin
        if (!en_q) state_d = OWT_IDLE;
        else if (start_end) state_d = OWT_BITS;
      end
      OWT_BITS: begin
        if (!en_q) state_d = OWT_IDLE; // [R5]
        else if (sym_end && bit_q == 3'h7) state_d = OWT_HOLD;
      end
      // [R3] open transfer: next byte goes straight out, no start symbol
      OWT_HOLD: begin
        if (!en_q || last_q || last_wr) state_d = OWT_IDLE; // [R1]
        else if (start_ok) state_d = OWT_BITS;
      end
      default: begin
        state_d = OWT_IDLE;
      end
    endcase
  end

  wire byte_done = state_q == OWT_BITS && state_d == OWT_HOLD; // [R2] [R13]

  // [R14] idle line high, start symbol low, bits begin high
  wire line_d = (state_d == OWT_START) ? 1'b0 :
                (state_d == OWT_BITS)  ? ((state_q == OWT_BITS && !sym_end)
                                          ? ((unit_q >= 6'(sym_len) - 6'h1 ||
                                             (tick && unit_q == 6'(sym_len) - 6'h2)) ? 1'b0
                                             : (cur_bit || unit_q == 6'h0 && !tick))
                                          : 1'b1)
                                       : 1'b1;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q   <= 1'b0;
      msbf_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        en_q   <= bus.wdata[BIT_EN];
        msbf_q <= bus.wdata[BIT_MSBF];
      end
      // [R1] remembered until byte in flight ends
      if (state_d == OWT_IDLE) last_q <= 1'b0;
      else if (last_wr) last_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tsel_q  <= 4'h0;
      ratio_q <= 1'b0;
      ien_q   <= 1'b0;
      data_q  <= 8'h00;
    end else begin
      if (wr_tim) begin
        tsel_q  <= bus.wdata[TB_LO +: 4];
        ratio_q <= bus.wdata[BIT_RATIO];
      end
      if (wr_evt) ien_q <= bus.wdata[BIT_IEN];
      if (wr_byte) data_q <= bus.wdata[7:0];
    end
  end

  // [R8] set wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) done_q <= 1'b0;
    else if (byte_done) done_q <= 1'b1;
    else if (wr_evt && bus.wdata[BIT_DONE]) done_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= OWT_IDLE;
      tick_q  <= 17'h0;
      unit_q  <= 6'h0;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      line_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      line_q  <= line_d;
      if (state_d != state_q || tick) tick_q <= 17'h0;
      else tick_q <= tick_q + 17'h1;
      if (state_d != state_q) unit_q <= 6'h0;
      else if (sym_end && state_q == OWT_BITS) unit_q <= 6'h0;
      else if (tick) unit_q <= unit_q + 6'h1;
      if (start_ok && (state_q == OWT_IDLE || state_q == OWT_HOLD)) begin
        shift_q <= bus.wdata[7:0];
        bit_q   <= 3'h0;
      end else if (state_q == OWT_BITS && sym_end) begin
        shift_q <= shifted;
        bit_q   <= bit_q + 3'h1;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  wire [31:0] rd_cfg  = 32'({msbf_q, en_q}); // [R1] last-byte reads 0
  wire [31:0] rd_tim  = 32'({tsel_q, 3'h0, ratio_q});
  wire [31:0] rd_evt  = 32'({done_q, 3'h0, ien_q});
  wire [31:0] rd_byte = 32'(data_q);
  wire [31:0] rd_mux  =
    (bus.addr == OFS_CONFIG) ? rd_cfg :
    (bus.addr == OFS_TIMING) ? rd_tim :
    (bus.addr == OFS_EVENT)  ? rd_evt :
    (bus.addr == OFS_TXBYTE) ? rd_byte : 32'h0;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_q <= 32'h0;
    else rdata_q <= bus.rd ? rd_mux : 32'h0;
  end

  assign rdata_o = rdata_q;
  assign irq_o   = done_q && ien_q; // [R9]
  assign line_o  = line_q;          // [R12]

  a_irq_follows: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R9]
    irq_o == (done_q && ien_q))
    else $error("irq mismatch");

  a_done_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R8]
    done_q && !(wr_evt && wdata_i[BIT_DONE]) |=> done_q)
    else $error("flag lost");

  a_done_set: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R2]
    byte_done |=> done_q)
    else $error("no done");

  a_disabled_idle: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    !en_q |=> state_q == OWT_IDLE)
    else $error("sent while off");

  a_start_byte: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
    state_q == OWT_IDLE && en_q && wr_byte |=> state_q == OWT_START)
    else $error("no start");

  a_last_ends: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R1]
    state_q == OWT_HOLD && (last_q || last_wr) |=> state_q == OWT_IDLE ##1 line_o)
    else $error("no end");

  a_hold_open: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R3]
    state_q == OWT_HOLD && en_q && !last_q && !last_wr && !wr_byte |=> state_q == OWT_HOLD)
    else $error("left open transfer");

  a_cfg_readback: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
    rd_i && addr_i == OFS_CONFIG |=> rdata_o[BIT_LAST] == 1'b0)
    else $error("last reads 1");

  a_idle_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
    state_q == OWT_IDLE && $past(state_q) == OWT_IDLE |-> line_o)
    else $error("idle low");

  // multi-step sequences and further checks
  sequence s_idle_start;
    state_q == OWT_IDLE && en_q && wr_byte;
  endsequence

  sequence s_byte_end;
    state_q == OWT_BITS ##1 state_q == OWT_HOLD;
  endsequence

  sequence s_clear_req;
    wr_evt && wdata_i[BIT_DONE] && !byte_done;
  endsequence

  a_byte_flag: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R2]
    s_byte_end |-> done_q)
    else $error("byte end without flag");

  a_start_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
    s_idle_start |=> (state_q == OWT_START && !line_o) ##1 !line_o)
    else $error("start not low");

  a_rdata_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R11]
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data without strobe");

  a_one_event: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R13]
    byte_done |=> !byte_done)
    else $error("double event");

  a_abort_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
    wr_cfg && !wdata_i[BIT_EN] |=> ##1 state_q == OWT_IDLE)
    else $error("no abort on disable");

  a_hold_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
    state_q == OWT_HOLD |-> line_o)
    else $error("hold line low");

  a_load_byte: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
    s_idle_start |=> shift_q == $past(wdata_i[7:0]))
    else $error("byte not loaded");

  a_msb_next: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    state_q == OWT_BITS && sym_end && msbf_q |=> !msbf_q || cur_bit == $past(shift_q[6]))
    else $error("msb order wrong");

  a_lsb_next: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R4]
    state_q == OWT_BITS && sym_end && !msbf_q |=> msbf_q || cur_bit == $past(shift_q[1]))
    else $error("lsb order wrong");

  a_sym_units: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R7]
    state_q == OWT_BITS |-> unit_q <= 6'(SYM_UNITS_31) - 6'h1)
    else $error("symbol too long");

  a_start_units: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R14]
    state_q == OWT_START |-> unit_q < START_UNITS)
    else $error("start too long");

  a_last_idle: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R1]
    state_q == OWT_IDLE |-> !last_q)
    else $error("stale last-byte");

  a_flag_clear: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R8]
    s_clear_req |=> !done_q)
    else $error("flag not cleared");

  a_data_store: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R10]
    wr_byte |=> data_q == $past(wdata_i[7:0]))
    else $error("data not stored");

  a_irq_masked: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R9]
    !ien_q |-> !irq_o)
    else $error("irq while masked");
endmodule
`default_nettype wire

// *** bench/owt_rx_model.sv ***
/*
  receive-only model of the display instrument on the single line.
  assumes an idle-high line, a long low start and one unit of UNIT cycles.
*/
`default_nettype none
module owt_rx_model #(
  parameter int UNIT = 32
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  output logic      [7:0] byte_o,
  output int              cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         lo = 0;
  // idle and open transfers leave the line high, so only the low time decides
  wire logic  bit1 = 2 * lo < 3 * UNIT;
  int         nb = 0;
  logic       prev = 1'b1;
  logic [6:0] sh = '0;
  initial cnt_o = 0;
  // listens only, never drives the line
  always @(posedge clk_i) begin
    prev <= line_i;
    if (!line_i) lo <= lo + 1;
    if (line_i && !prev) begin // a rise ends each symbol
      lo <= 0;
      if (lo > 8 * UNIT) nb <= 0; // long low is a start
      else if (nb == 7) begin
        byte_o <= {sh, bit1};
        cnt_o  <= cnt_o + 1;
        nb     <= 0;
      end else begin
        sh <= {sh[5:0], bit1};
        nb <= nb + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
/*
  self-checking bench for the one-wire byte transmitter.
  assumes CLK_MHZ lowered to 1 so one 32us unit is 32 cycles.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import owt_pkg::*;
  logic        clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0]  addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [31:0] rdata_o;
  logic        irq_o, line_o;
  logic [7:0]  rx_byte;
  int          rx_cnt, num_errors = 0, n_checks = 0, cyc = 0;
  owt_top #(.CLK_MHZ(1)) i_owt_top (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .line_o(line_o));
  owt_rx_model #(.UNIT(32)) i_owt_rx_model (.clk_i(clk_i), .line_i(line_o), .byte_o(rx_byte), .cnt_o(rx_cnt));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bytes take about 2k cycles; generous ceiling
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check(n, rdata_o, e);
  endtask
  task automatic wait_rx(int n);
    for (int i = 0; i < 4000 && rx_cnt < n; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    check("rx count", rx_cnt, n);
  endtask
  task automatic t_reset();
    logic [3:0] ofs [5] = '{OFS_CONFIG, OFS_TIMING, OFS_EVENT, OFS_TXBYTE, 4'h1};
    foreach (ofs[i])
      rd(ofs[i], '0, "reset value");
    $display("reset test done");
  endtask
  task automatic t_disabled();
    wr(OFS_TXBYTE, 32'h55);
    repeat (300) @(posedge clk_i);
    check("line idle", line_o, 1'b1);
    check("no byte", rx_cnt, 0);
    rd(OFS_TXBYTE, 32'h55, "tx store");
    $display("disabled test done");
  endtask
  task automatic t_msb();
    wr(OFS_TIMING, 32'h11);
    wr(OFS_EVENT, 32'h01);
    wr(OFS_CONFIG, 32'h03);
    wr(OFS_TXBYTE, 32'ha5);
    wait_rx(1);
    check("msb byte", rx_byte, 8'ha5);
    check("irq set", irq_o, 1'b1);
    rd(OFS_EVENT, 32'h11, "event reg");
    wr(OFS_EVENT, 32'h01);
    @(negedge clk_i);
    check("flag kept", irq_o, 1'b1);
    wr(OFS_EVENT, 32'h11);
    @(negedge clk_i);
    check("flag clear", irq_o, 1'b0);
    wr(OFS_TXBYTE, 32'h3c);
    wait_rx(2);
    check("open byte", rx_byte, 8'h3c);
    wr(OFS_CONFIG, 32'h13);
    rd(OFS_CONFIG, 32'h03, "last reads 0");
    check("idle line", line_o, 1'b1);
    $display("msb test done");
  endtask
  task automatic t_lsb();
    wr(OFS_TIMING, 32'hb0);
    wr(OFS_EVENT, 32'h10);
    wr(OFS_CONFIG, 32'h01);
    wr(OFS_TXBYTE, 32'h13);
    wait_rx(3);
    check("lsb byte", rx_byte, 8'hc8);
    rd(OFS_EVENT, 32'h10, "masked flag");
    check("irq masked", irq_o, 1'b0);
    $display("lsb test done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_disabled();
    t_msb();
    t_lsb();
    end_of_test();
  end
endmodule
`default_nettype wire
